// *** src/ebp_pkg.sv ***
// Purpose: shared constants for the enhanced bridge pwm core
// Assumes: 32-bit ahb-lite register window, one word per register
// Notes:   all offsets are byte addresses inside the window
package ebp_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00; // channel_control_reg
  localparam logic [7:0] OFF_DUTY_W   = 8'h04; // duty_write_reg
  localparam logic [7:0] OFF_DUTY_A   = 8'h08; // duty_active_reg
  localparam logic [7:0] OFF_PERIOD   = 8'h0c; // period_limit_reg
  localparam logic [7:0] OFF_TIMER    = 8'h10; // pwm_base_timer
  localparam logic [7:0] OFF_TCFG     = 8'h14; // prescale, enable, postscale
  localparam logic [7:0] OFF_ROUTE    = 8'h18; // timer_route_control
  localparam logic [7:0] OFF_DEADBAND = 8'h1c; // deadband_reg
  localparam logic [7:0] OFF_CAP_A    = 8'h20; // capture_timer_a
  localparam logic [7:0] OFF_CAP_B    = 8'h24; // capture_timer_b
  localparam logic [7:0] OFF_STATUS   = 8'h28; // sticky flags, w1c
  // ==========================================================
  // field positions
  localparam int CTRL_CFG_HI  = 7;  // output_config_bits 7:6
  localparam int CTRL_CFG_LO  = 6;
  localparam int CTRL_LSB_HI  = 5;  // duty low bits 5:4
  localparam int CTRL_LSB_LO  = 4;
  localparam int CTRL_FSEL_HI = 3;  // function_select_bits 3:0
  localparam int TCFG_ON      = 2;  // timer run enable
  localparam int TCFG_PS_HI   = 6;  // postscale 6:3
  localparam int TCFG_PS_LO   = 3;
  localparam int ROUTE_CAP_B  = 0;  // capture base is timer b
  localparam int ROUTE_ALT    = 1;  // pwm base is the fourth timer
  localparam int ST_POST      = 0;  // postscaler event
  localparam int ST_CMP       = 1;  // compare match
  localparam int ST_RUN       = 2;  // pwm running (read only)
  // ==========================================================
  // codes and counts
  localparam logic [1:0] FSEL_PWM     = 2'b11; // function_select 3:2 pwm
  localparam logic [1:0] FSEL_CMP     = 2'b10; // function_select 3:2 compare
  localparam logic [3:0] FSEL_TRIG    = 4'hb;  // compare with special event
  localparam logic [1:0] PRE_DIV1     = 2'h0;  // prescale 1
  localparam logic [1:0] PRE_DIV4     = 2'h1;  // prescale 4, 2/3 give 16
  localparam logic [1:0] Q_LAST       = 2'h3;  // 4 osc clocks per instr
  localparam logic [3:0] PRE_LAST16   = 4'hf;
  localparam logic [1:0] PRE_LAST4    = 2'h3;
  localparam int         DB_W         = 7;     // dead-band count width
  // ==========================================================
  // pin slots
  localparam int PIN_A      = 0;
  localparam int PIN_B_MAIN = 1;
  localparam int PIN_B_ALT  = 2;
  localparam int PIN_C_MAIN = 3;
  localparam int PIN_C_ALT  = 4;
  localparam int PIN_D      = 5;
  localparam int PIN_N      = 6;
  typedef enum logic [1:0] {
    CFG_SINGLE = 2'b00,
    CFG_FWD    = 2'b01,
    CFG_HALF   = 2'b10,
    CFG_REV    = 2'b11
  } ebp_cfg_e;
endpackage

// *** src/ebp_core.sv ***
// Purpose: enhanced capture/compare/pwm channel with bridge outputs
// Assumes: ahb-lite slave, single word transfers, clk is the oscillator
// Notes:   instruction cycle is four clk periods
//
// What this block does
// - config field picks single, dual or quad outputs
// - neighbour channel output overrides D in quad
// - compare uses timers a/b, pwm second/fourth
// - compare match special event resets capture timer
// - up to four outputs A-D, backward compatible
// - software selects active-high or active-low outputs
// - config bits 7:6, mode bits 3:0
// - pwm controls double-buffered, loaded at period boundary
// - dead-band loaded at duty or period boundary
// - pwm starts only after timer reset
// - period is (limit+1) x 4 osc x prescale
// - period match clears timer, sets output, loads duty
// - postscaler only gives a slower update event
// - 10-bit duty: eight in duty reg, two in ctrl
// - duty writes anytime, active duty read-only in pwm
// - output clears when duty equals timer plus phase
// - duty above period keeps output set all cycle
// - prescaler divides by 1, 4 or 16
// - single, half, full forward, full reverse arrangements
// - single output acts as standard pwm
// - steer bit 0 moves B,C to alternate pins
// - half-bridge delays active edges by dead-band count
// - half-bridge drives pwm on A, complement B
//
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
module ebp_core (
  input  wire logic                    clk,              // oscillator clock
  input  wire logic                    rst_n,            // async reset, low
  input  wire logic                    hsel,             // slave select
  input  wire logic [31:0]             haddr,            // byte address
  input  wire logic [1:0]              htrans,           // transfer type
  input  wire logic                    hwrite,           // write when high
  input  wire logic [2:0]              hsize,            // word only
  input  wire logic [31:0]             hwdata,           // write data
  input  wire logic                    hready,           // bus ready in
  output logic      [31:0]             hrdata,           // read data
  output logic                         hreadyout,        // slave ready
  output logic                         hresp,            // always okay
  input  wire logic                    pin_steer_select, // 0 = alt B/C pins
  input  wire logic                    ext_bus_wide,     // main B/C carry addr
  input  wire logic                    neighbour_out,    // neighbour level
  input  wire logic                    neighbour_active, // neighbour drives
  input  wire logic [7:0]              alt_timer_val,    // fourth timer value
  input  wire logic                    alt_period_hit,   // fourth timer wrap
  output logic      [ebp_pkg::PIN_N-1:0] pin_level,      // pin levels
  output logic      [ebp_pkg::PIN_N-1:0] pin_own,        // pin owned by pwm
  output logic                         special_event,    // trigger pulse
  output logic                         post_event        // postscaler pulse
);
  import ebp_pkg::*;

  // ==========================================================
  // state
  logic        wr_pend_r, wr_pend_nxt;        // write data phase due
  logic [7:0]  wr_addr_r, wr_addr_nxt;        // latched write offset
  logic [31:0] hrdata_r, hrdata_nxt;          // read data flop
  logic        ready_r;                       // ready flop
  logic [7:0]  ctrl_r, ctrl_nxt;              // channel_control_reg
  logic [7:0]  duty_w_r, duty_w_nxt;          // duty_write_reg
  logic [7:0]  duty_a_r, duty_a_nxt;          // duty_active_reg
  logic [1:0]  lat_r, lat_nxt;                // hidden 2-bit duty latch
  logic [7:0]  period_r, period_nxt;          // period_limit_reg
  logic [7:0]  timer_r, timer_nxt;            // pwm_base_timer
  logic [6:0]  tcfg_r, tcfg_nxt;              // timer config
  logic [1:0]  route_r, route_nxt;            // timer_route_control
  logic [DB_W-1:0] db_r, db_nxt;              // deadband_reg
  logic [DB_W-1:0] db_act_r, db_act_nxt;      // live dead-band count
  logic [15:0] cap_r [2];                     // capture timers a, b
  logic [15:0] cap_nxt [2];
  logic [1:0]  flag_r, flag_nxt;              // sticky status
  logic [1:0]  q_r, q_nxt;                    // osc phase in instr cycle
  logic [3:0]  pc_r, pc_nxt;                  // prescale counter
  logic [3:0]  ps_r, ps_nxt;                  // postscale counter
  logic        run_r, run_nxt;                // pwm started
  logic        pwm_r, pwm_nxt;                // raw modulated level
  ebp_cfg_e    cfg_r, cfg_nxt;                // buffered output config
  logic [1:0]  pol_r, pol_nxt;                // buffered polarity
  logic [DB_W-1:0] dc_r [2];                  // dead-band counters A, B
  logic [DB_W-1:0] dc_nxt [2];
  logic [PIN_N-1:0] lvl_nxt, own_nxt;         // pin next values
  logic        sev_r, sev_nxt;                // special event pulse
  logic        pev_r, pev_nxt;                // postscale pulse

  // ==========================================================
  // helpers
  logic        icyc;                          // last osc of instr cycle
  logic        tick;                          // prescaled timer step
  logic [1:0]  phase;                         // sub-count below timer
  logic        own_bnd;                       // own period match step
  logic        bnd;                           // selected period boundary
  logic [7:0]  tb;                            // selected pwm timer value
  logic        pwm_mode;                      // function select is pwm
  logic        duty_hit;                      // duty compare match
  logic        cmp_hit;                       // compare mode match
  logic        cap_sel;                       // selected capture timer

  // data-phase write to a given offset
  function automatic logic wsel(input logic [7:0] off);
    wsel = wr_pend_r && (wr_addr_r == off);
  endfunction

  // read mux for the register window, unmapped reads as zero
  function automatic logic [31:0] rd_mux(input logic [7:0] off);
    rd_mux = 32'h0;
    case (off)
      OFF_CTRL:     rd_mux = {24'h0, ctrl_r};
      OFF_DUTY_W:   rd_mux = {24'h0, duty_w_r};
      OFF_DUTY_A:   rd_mux = {24'h0, duty_a_r};
      OFF_PERIOD:   rd_mux = {24'h0, period_r};
      OFF_TIMER:    rd_mux = {24'h0, timer_r};
      OFF_TCFG:     rd_mux = {25'h0, tcfg_r};
      OFF_ROUTE:    rd_mux = {30'h0, route_r};
      OFF_DEADBAND: rd_mux = {25'h0, db_r};
      OFF_CAP_A:    rd_mux = {16'h0, cap_r[0]};
      OFF_CAP_B:    rd_mux = {16'h0, cap_r[1]};
      OFF_STATUS:   rd_mux = {29'h0, run_r, flag_r};
      default:      rd_mux = 32'h0;
    endcase
  endfunction

  // ==========================================================
  // bus slave: zero wait, read data staged from the address phase
  always_comb
  begin
    wr_pend_nxt = hsel && htrans[1] && hready && hwrite;
    wr_addr_nxt = wr_addr_r;
    hrdata_nxt  = 32'h0;
    if (hsel && htrans[1] && hready)
    begin
      wr_addr_nxt = haddr[7:0];
      if (!hwrite)
        hrdata_nxt = rd_mux(haddr[7:0]);      // stands for the data phase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h0;
      hrdata_r  <= 32'h0;
      ready_r   <= 1'b0;
    end
    else
    begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r  <= hrdata_nxt;
      ready_r   <= 1'b1;                      // never stalls after reset
    end
  end

  // ==========================================================
  // time base: instruction cycle, prescaler, period timer
  always_comb
  begin
    q_nxt  = q_r + 2'h1;
    icyc   = (q_r == Q_LAST);
    pc_nxt = icyc ? pc_r + 4'h1 : pc_r;
    case (tcfg_r[1:0])
      PRE_DIV1:
      begin
        tick  = icyc;
        phase = q_r;                          // osc-phase resolution
      end
      PRE_DIV4:
      begin
        tick  = icyc && (pc_r[1:0] == PRE_LAST4);
        phase = pc_r[1:0];                    // prescaler bits
      end
      default:
      begin
        tick  = icyc && (pc_r == PRE_LAST16);
        phase = pc_r[3:2];
      end
    endcase
    // limit+1 steps of 4 osc x prescale
    own_bnd   = tick && tcfg_r[TCFG_ON] && (timer_r == period_r);
    timer_nxt = timer_r;
    if (wsel(OFF_TIMER))
      timer_nxt = hwdata[7:0];
    else if (tick && tcfg_r[TCFG_ON])
      timer_nxt = own_bnd ? 8'h0 : timer_r + 8'h1; // clear on match
    // postscaler counts boundaries only, never alters the period
    ps_nxt  = ps_r;
    pev_nxt = 1'b0;
    if (own_bnd)
    begin
      if (ps_r == tcfg_r[TCFG_PS_HI:TCFG_PS_LO])
      begin
        ps_nxt  = 4'h0;
        pev_nxt = 1'b1;
      end
      else
        ps_nxt = ps_r + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q_r     <= 2'h0;
      pc_r    <= 4'h0;
      timer_r <= 8'h0;
      ps_r    <= 4'h0;
      pev_r   <= 1'b0;
    end
    else
    begin
      q_r     <= q_nxt;
      pc_r    <= pc_nxt;
      timer_r <= timer_nxt;
      ps_r    <= ps_nxt;
      pev_r   <= pev_nxt;
    end
  end

  // ==========================================================
  // capture timers and compare with special event trigger
  always_comb
  begin
    cap_sel = route_r[ROUTE_CAP_B];           // timer a or b
    cmp_hit = (ctrl_r[CTRL_FSEL_HI -: 2] == FSEL_CMP) && icyc
              && (cap_r[cap_sel] == {duty_a_r, duty_w_r});
    sev_nxt = cmp_hit && (ctrl_r[CTRL_FSEL_HI:0] == FSEL_TRIG);
    for (int i = 0; i < 2; i++)
    begin
      if (wsel(i == 0 ? OFF_CAP_A : OFF_CAP_B))
        cap_nxt[i] = hwdata[15:0];
      else if (sev_nxt && (cap_sel == i[0]))
        cap_nxt[i] = 16'h0;                   // 16-bit period reset
      else if (icyc)
        cap_nxt[i] = cap_r[i] + 16'h1;
      else
        cap_nxt[i] = cap_r[i];
    end
    // sticky flags: w1c, but a new event in the same cycle wins
    flag_nxt = flag_r;
    if (wsel(OFF_STATUS))
      flag_nxt = flag_r & ~hwdata[1:0];
    if (pev_nxt)
      flag_nxt[ST_POST] = 1'b1;
    if (cmp_hit)
      flag_nxt[ST_CMP] = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_r[0] <= 16'h0;
      cap_r[1] <= 16'h0;
      flag_r   <= 2'h0;
      sev_r    <= 1'b0;
    end
    else
    begin
      cap_r[0] <= cap_nxt[0];
      cap_r[1] <= cap_nxt[1];
      flag_r   <= flag_nxt;
      sev_r    <= sev_nxt;
    end
  end

  // ==========================================================
  // software registers and the pwm engine
  always_comb
  begin
    ctrl_nxt   = wsel(OFF_CTRL)     ? hwdata[7:0]      : ctrl_r;
    duty_w_nxt = wsel(OFF_DUTY_W)   ? hwdata[7:0]      : duty_w_r;
    period_nxt = wsel(OFF_PERIOD)   ? hwdata[7:0]      : period_r;
    tcfg_nxt   = wsel(OFF_TCFG)     ? hwdata[6:0]      : tcfg_r;
    route_nxt  = wsel(OFF_ROUTE)    ? hwdata[1:0]      : route_r;
    db_nxt     = wsel(OFF_DEADBAND) ? hwdata[DB_W-1:0] : db_r;
    pwm_mode   = (ctrl_r[CTRL_FSEL_HI -: 2] == FSEL_PWM);
    // pwm runs on the second timer or the fourth one
    bnd        = route_r[ROUTE_ALT] ? alt_period_hit : own_bnd;
    tb         = route_r[ROUTE_ALT] ? alt_timer_val  : timer_r;
    // timer and phase against 10-bit active duty
    // a duty above the period never matches, so stays set
    duty_hit   = run_r && ({tb, phase} == {duty_a_r, lat_r});
    run_nxt    = run_r;
    pwm_nxt    = pwm_r;
    duty_a_nxt = duty_a_r;
    lat_nxt    = lat_r;
    cfg_nxt    = cfg_r;
    pol_nxt    = pol_r;
    // active duty writable only outside pwm, where it is compare high
    if (wsel(OFF_DUTY_A) && !pwm_mode)
      duty_a_nxt = hwdata[7:0];
    if (!pwm_mode)
    begin
      run_nxt = 1'b0;
      pwm_nxt = 1'b0;
    end
    else if (bnd)
    begin
      run_nxt    = 1'b1;                      // start waits for reset
      duty_a_nxt = duty_w_r;
      lat_nxt    = ctrl_r[CTRL_LSB_HI:CTRL_LSB_LO];
      cfg_nxt    = ebp_cfg_e'(ctrl_r[CTRL_CFG_HI:CTRL_CFG_LO]);
      pol_nxt    = ctrl_r[1:0];
      // set at period start unless duty is zero
      pwm_nxt    = ({duty_w_r, ctrl_r[CTRL_LSB_HI:CTRL_LSB_LO]} != 10'h0);
    end
    else if (duty_hit)
      pwm_nxt = 1'b0;
    // dead-band taken at whichever boundary comes first
    db_act_nxt = (bnd || duty_hit) ? db_r : db_act_r;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r   <= 8'h0;
      duty_w_r <= 8'h0;
      duty_a_r <= 8'h0;
      lat_r    <= 2'h0;
      period_r <= 8'h0;
      tcfg_r   <= 7'h0;
      route_r  <= 2'h0;
      db_r     <= '0;
      db_act_r <= '0;
      run_r    <= 1'b0;
      pwm_r    <= 1'b0;
      cfg_r    <= CFG_SINGLE;
      pol_r    <= 2'h0;
    end
    else
    begin
      ctrl_r   <= ctrl_nxt;
      duty_w_r <= duty_w_nxt;
      duty_a_r <= duty_a_nxt;
      lat_r    <= lat_nxt;
      period_r <= period_nxt;
      tcfg_r   <= tcfg_nxt;
      route_r  <= route_nxt;
      db_r     <= db_nxt;
      db_act_r <= db_act_nxt;
      run_r    <= run_nxt;
      pwm_r    <= pwm_nxt;
      cfg_r    <= cfg_nxt;
      pol_r    <= pol_nxt;
    end
  end

  // ==========================================================
  // output shaping: dead band, arrangement, polarity, steering
  logic [1:0] hb_raw;                         // half-bridge raw A, B
  logic [3:0] act;                            // active sense A..D
  logic [3:0] lvl;                            // after polarity
  logic       pwm_live;                       // pwm with duty match applied
  always_comb
  begin
    // drop in the match cycle itself, so the high time is exactly
    // duty x prescale osc clocks rather than one clock more
    pwm_live  = pwm_r && !duty_hit;
    // pwm on A, complement on B
    hb_raw[0] = run_r && pwm_live;
    hb_raw[1] = run_r && !pwm_live;
    for (int i = 0; i < 2; i++)
    begin
      // count reloads while low, so delay longer than the pulse
      // keeps the output inactive for the whole pulse
      if (!hb_raw[i])
        dc_nxt[i] = db_act_r;
      else if (icyc && (dc_r[i] != '0))
        dc_nxt[i] = dc_r[i] - 7'h1;
      else
        dc_nxt[i] = dc_r[i];
    end
    act = 4'h0;
    if (run_r)
    begin
      case (cfg_r)
        CFG_SINGLE: act[0] = pwm_live;        // standard pwm
        CFG_HALF:
        begin
          act[0] = hb_raw[0] && (dc_r[0] == '0);
          act[1] = hb_raw[1] && (dc_r[1] == '0);
        end
        CFG_FWD:
        begin
          act[0] = 1'b1;
          act[3] = pwm_live;
        end
        CFG_REV:
        begin
          act[2] = 1'b1;
          act[1] = pwm_live;
        end
        default: act = 4'h0;
      endcase
    end
    // bit 1 inverts A and C, bit 0 inverts B and D
    lvl[0] = act[0] ^ pol_r[1];
    lvl[2] = act[2] ^ pol_r[1];
    lvl[1] = act[1] ^ pol_r[0];
    lvl[3] = act[3] ^ pol_r[0];
    // pin ownership only; direction stays with software
    own_nxt = '0;
    lvl_nxt = '0;
    lvl_nxt[PIN_A] = lvl[0];
    own_nxt[PIN_A] = pwm_mode;
    if (pin_steer_select)
    begin
      lvl_nxt[PIN_B_MAIN] = lvl[1];
      lvl_nxt[PIN_C_MAIN] = lvl[2];
      // wide external bus keeps the main pins for address
      own_nxt[PIN_B_MAIN] = pwm_mode && (ctrl_r[CTRL_CFG_HI] || ctrl_r[CTRL_CFG_LO])
                            && !ext_bus_wide;
      own_nxt[PIN_C_MAIN] = pwm_mode && ctrl_r[CTRL_CFG_LO] && !ext_bus_wide;
    end
    else
    begin
      lvl_nxt[PIN_B_ALT] = lvl[1];
      lvl_nxt[PIN_C_ALT] = lvl[2];
      own_nxt[PIN_B_ALT] = pwm_mode && (ctrl_r[CTRL_CFG_HI] || ctrl_r[CTRL_CFG_LO]);
      own_nxt[PIN_C_ALT] = pwm_mode && ctrl_r[CTRL_CFG_LO];
    end
    own_nxt[PIN_D] = pwm_mode && ctrl_r[CTRL_CFG_LO]; // quad only
    lvl_nxt[PIN_D] = (own_nxt[PIN_D] && neighbour_active)
                     ? neighbour_out : lvl[3]; // neighbour wins
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dc_r[0]   <= '0;
      dc_r[1]   <= '0;
      pin_level <= '0;
      pin_own   <= '0;
    end
    else
    begin
      dc_r[0]   <= dc_nxt[0];
      dc_r[1]   <= dc_nxt[1];
      pin_level <= lvl_nxt;
      pin_own   <= own_nxt;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign hrdata        = hrdata_r;
  assign hreadyout     = ready_r;
  assign hresp         = 1'b0 & ready_r;      // okay only
  assign special_event = sev_r;
  assign post_event    = pev_r;
endmodule

// *** test/ebp_bridge_drv.sv ***
// Purpose: bridge switch driver model on the A and B legs
// Assumes: active-high legs, one clock
// Notes:   counts cycles with both switches of one leg pair on
`timescale 1ns/10ps
module ebp_bridge_drv (
  input  wire logic        clk,     // sampling clock
  input  wire logic        hi_on,   // upper switch gate
  input  wire logic        lo_on,   // lower switch gate
  output logic      [15:0] overlap  // shoot-through cycles seen
);
  // ==========================================
  // both gates on shorts the supply
  initial overlap = 16'h0;
  always @(posedge clk)
    if (hi_on && lo_on)
      overlap <= overlap + 16'h1;
endmodule

// *** test/ebp_core_asserts.sv ***
// Purpose: port checks for the pwm core
// Assumes: one clock, async low reset
// Notes:   bound onto every ebp_core
`timescale 1ns/10ps
module ebp_core_chk
  import ebp_pkg::*;
(
  input wire logic              clk, rst_n, hsel, hwrite, hready, // bus side
  input wire logic [1:0]        htrans,                           // transfer type
  input wire logic [31:0]       hrdata,                           // read data
  input wire logic              hreadyout, hresp,                 // answer
  input wire logic              pin_steer_select, ext_bus_wide,   // pin routing
  input wire logic [PIN_N-1:0]  pin_level, pin_own,               // pins
  input wire logic              special_event, post_event         // pulses
);
  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
  a_ready_up: assert property ($past(rst_n) |-> hreadyout) else $error("ready low");
  a_rdata_idle: assert property (!$past(hsel && htrans[1] && hready && !hwrite)
    |-> hrdata == 32'h0) else $error("read data outside data phase");
  a_trig_pulse: assert property (special_event |=> !special_event)
    else $error("trigger longer than one cycle");
  a_post_pulse: assert property (post_event |=> !post_event)
    else $error("postscale event longer than one cycle");
  a_steer_main: assert property (!pin_steer_select && $past(!pin_steer_select)
    |-> !pin_own[PIN_B_MAIN] && !pin_own[PIN_C_MAIN]) else $error("main pin owned");
  a_steer_alt: assert property (pin_steer_select && $past(pin_steer_select)
    |-> !pin_own[PIN_B_ALT] && !pin_own[PIN_C_ALT]) else $error("alt pin owned");
  a_bus_wide: assert property (ext_bus_wide && pin_steer_select
    && $past(ext_bus_wide && pin_steer_select) |-> pin_own[PIN_B_MAIN] == 1'b0)
    else $error("address pin taken by pwm");
  a_idle_pins: assert property (!$past(rst_n) |-> (pin_level == 6'h0)[*3])
    else $error("pins active before set up");
endmodule
bind ebp_core ebp_core_chk u_chk (.clk, .rst_n, .hsel, .hwrite, .hready, .htrans,
  .hrdata, .hreadyout, .hresp, .pin_steer_select, .ext_bus_wide, .pin_level,
  .pin_own, .special_event, .post_event);

// *** test/ebp_core_tb.sv ***
// Purpose: self-checking bench for the pwm core
// Assumes: 200 MHz clock, zero wait state bus
// Notes:   pulse widths measured between rising edges of A
`timescale 1ns/10ps
module ebp_core_tb;
  import ebp_pkg::*;
  logic clk, rst_n, hsel, hwrite, hrdy, hresp, steer, wide, nb_out, nb_act, alt_hit;
  logic sev, pev, a_q, rd_ph;
  logic [1:0] htrans;
  logic [7:0] alt_val;
  logic [31:0] haddr, hwdata, hrdata, q_rd[$];
  logic [5:0] lvl, own;
  logic [15:0] ovl;
  int miscompares, check_count, seed, hi_n, per_n, d, m, n, q_pw[$];
  ebp_core u_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
    .hreadyout(hrdy), .hresp(hresp), .pin_steer_select(steer), .ext_bus_wide(wide),
    .neighbour_out(nb_out), .neighbour_active(nb_act), .alt_timer_val(alt_val),
    .alt_period_hit(alt_hit), .pin_level(lvl), .pin_own(own), .special_event(sev),
    .post_event(pev));
  ebp_bridge_drv u_drv (.clk(clk), .hi_on(lvl[PIN_A]), .lo_on(lvl[PIN_B_MAIN]),
    .overlap(ovl));
  // ==========================================
  // helpers
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h0, a};
    do @(posedge clk); while (!hrdy);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= v;
    do @(posedge clk); while (!hrdy);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    q_rd.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task hold(input int k, input int p, input logic e);
    repeat (k) @(posedge clk);
    for (int j = 0; j < 40; j++)
    begin
      @(posedge clk);
      chk(lvl[p], e);
    end
  endtask
  task close_out;
    if (miscompares == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================
  // clock, random side inputs, watchdog
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    alt_val <= $random(seed);
    alt_hit <= $random(seed);
  end
  initial
  begin
    #150000;
    miscompares++;
    close_out;
  end
  // ==========================================
  // monitors: read data and pulse widths of A
  always @(posedge clk)
  begin
    if (rd_ph && hrdy)
      chk(hrdata, q_rd.pop_front());
    if (hrdy)
      rd_ph <= hsel && htrans[1] && !hwrite;
    hi_n = hi_n + lvl[PIN_A];
    per_n = per_n + 1;
    if (lvl[PIN_A] && !a_q)
    begin
      if (q_pw.size() > 1)
      begin
        chk(per_n - 1, q_pw.pop_front());
        chk(hi_n - 1, q_pw.pop_front());
      end
      hi_n = 1;
      per_n = 1;
    end
    a_q = lvl[PIN_A];
  end
  // ==========================================
  // main sequence
  initial
  begin
    seed = 32'h812f; rst_n = 0; hsel = 0; htrans = 0; hwrite = 0; haddr = 0; hwdata = 0;
    steer = 1; wide = 0; nb_out = 0; nb_act = 0; alt_val = 0; alt_hit = 0;
    rd_ph = 0; a_q = 0; hi_n = 0; per_n = 0; miscompares = 0; check_count = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFF_PERIOD, 32'h0);
    bus(1'b1, OFF_PERIOD, 32'h9);
    rd(OFF_PERIOD, 32'h9);
    rd(8'h3c, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      d = 1 + ($unsigned($random(seed)) % 30);
      m = 1 << (2 * i);
      bus(1'b1, OFF_DUTY_W, d >> 2);
      bus(1'b1, OFF_CTRL, {24'h0, 2'b00, d[1:0], 4'hc});
      bus(1'b1, OFF_TCFG, {29'h0, 1'b1, i[1:0]});
      repeat (80 * m + 20) @(posedge clk);
      q_pw.push_back(40 * m);
      q_pw.push_back(d * m);
      repeat (40 * m + 20) @(posedge clk);
    end
    chk(own[PIN_B_MAIN], 0);
    bus(1'b1, OFF_DUTY_A, 32'h55);
    rd(OFF_DUTY_A, d >> 2);
    bus(1'b1, OFF_TCFG, 32'h4);
    bus(1'b1, OFF_DUTY_W, 32'h20);
    hold(100, PIN_A, 1'b1);
    bus(1'b1, OFF_DUTY_W, 32'h0);
    bus(1'b1, OFF_CTRL, 32'h0e);
    hold(100, PIN_A, 1'b1);
    bus(1'b1, OFF_CTRL, 32'h0c);
    hold(100, PIN_A, 1'b0);
    bus(1'b1, OFF_DUTY_W, 32'h3);
    bus(1'b1, OFF_CTRL, 32'h9c);
    rd(OFF_CTRL, 32'h9c);
    repeat (100) @(posedge clk);
    for (int j = 0; j < 40; j++)
    begin
      @(posedge clk);
      chk(lvl[PIN_B_MAIN], !lvl[PIN_A]);
    end
    bus(1'b1, OFF_DEADBAND, 32'h2);
    repeat (100) @(posedge clk);
    q_pw.push_back(40);
    q_pw.push_back(5);
    repeat (60) @(posedge clk);
    chk(ovl, 0);
    steer <= 1'b0;
    repeat (3) @(posedge clk);
    chk(own[PIN_B_ALT], 1);
    steer <= 1'b1;
    wide <= 1'b1;
    repeat (3) @(posedge clk);
    wide <= 1'b0;
    bus(1'b1, OFF_CTRL, 32'h5c);
    nb_act <= 1'b1;
    nb_out <= 1'b1;
    hold(100, PIN_D, 1'b1);
    chk(own[PIN_C_MAIN], 1);
    nb_out <= 1'b0;
    hold(3, PIN_D, 1'b0);
    chk(lvl[PIN_A], 1);
    bus(1'b1, OFF_CTRL, 32'h0b);
    bus(1'b1, OFF_DUTY_A, 32'h0);
    bus(1'b1, OFF_DUTY_W, 32'h10);
    bus(1'b1, OFF_CAP_A, 32'h0);
    n = 0;
    do @(posedge clk); while (!sev && ++n < 400);
    n = 0;
    do @(posedge clk); while (!sev && ++n < 400);
    chk(n + 1, 68);
    close_out;
  end
endmodule
